/* include/cw_pkg.sv */
package cw_pkg;

    // Control word bit positions
    localparam int CW_PRESET_LO   = 0;
    localparam int CW_PRESET_HI   = 1;
    localparam int CW_DC_BRAKE_N  = 2;
    localparam int CW_COAST_N     = 3;
    localparam int CW_QSTOP_N     = 4;
    localparam int CW_FREEZE_N    = 5;
    localparam int CW_RUN         = 6;
    localparam int CW_RESET       = 7;
    localparam int CW_JOG         = 8;
    localparam int CW_RAMP2       = 9;
    localparam int CW_VALID       = 10;
    localparam int CW_RELAY1      = 11;
    localparam int CW_RELAY4      = 12;
    localparam int CW_SETUP_LO    = 13;
    localparam int CW_SETUP_HI    = 14;
    localparam int CW_REVERSE     = 15;

    // Status word bit positions
    localparam int SW_CTRL_READY  = 0;
    localparam int SW_DRV_READY   = 1;
    localparam int SW_ENABLE      = 2;
    localparam int SW_TRIP        = 3;
    localparam int SW_ERROR       = 4;
    localparam int SW_UNUSED      = 5;
    localparam int SW_TRIPLOCK    = 6;
    localparam int SW_WARNING     = 7;
    localparam int SW_AT_REF      = 8;
    localparam int SW_BUS_CTRL    = 9;
    localparam int SW_FREQ_OK     = 10;
    localparam int SW_RUNNING     = 11;
    localparam int SW_AUTO_STOP   = 12;
    localparam int SW_VOLT_EXC    = 13;
    localparam int SW_TORQ_EXC    = 14;
    localparam int SW_TIMER_EXC   = 15;

    // Selection codes
    localparam logic [7:0] RELAY_FN_CW11 = 8'h24;
    localparam logic [7:0] RELAY_FN_CW12 = 8'h25;
    localparam logic [7:0] SETUP_MULTI   = 8'h09;

    // Reversing source choices
    typedef enum logic [1:0] {
        REV_DIGITAL,
        REV_SERIAL,
        REV_LOGIC_OR,
        REV_LOGIC_AND
    } rev_src_t;

    // Reference scaling: 0x4000 is 100 percent
    localparam logic signed [15:0] REF_FULL   = 16'sh4000;
    localparam int                 REF_SHIFT  = 14;

    // Reset values
    localparam logic [15:0] CW_RESET_VAL = 16'h0000;
    localparam logic [15:0] SW_RESET_VAL = 16'h0000;
    localparam logic [1:0]  SETUP_RESET  = 2'h0;

    // AXI4-Lite register byte offsets
    localparam logic [7:0] REG_CTRL_WORD  = 8'h00;
    localparam logic [7:0] REG_SPEED_REF  = 8'h04;
    localparam logic [7:0] REG_CONFIG     = 8'h08;
    localparam logic [7:0] REG_STATE_WORD = 8'h0C;
    localparam logic [7:0] REG_ACTUAL     = 8'h10;
    localparam logic [7:0] REG_COMMANDS   = 8'h14;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cw_pkg

/* design/drive_control_status_word.sv */
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Bits 0,1 pick one of four presets
// - Bit 2 low applies DC brake
// - Bit 3 low coasts, output stage off
// - Bit 4 low quick-stop ramp
// - Bit 5 low freezes output frequency
// - Freeze stops only by coast, brake, inputs
// - Bit 6 low ramps to stop
// - Trip reset on bit 7 rising edge
// - Bit 8 high selects jog speed
// - Bit 9 selects ramp set two
// - Bit 10 low ignores whole word
// - Relay one follows bit 11 at code 36
// - Relay four follows bit 12 at code 37
// - Bits 14,13 select set-up in multi mode
// - Bit 15 reverses with serial/or/and source
// - Status bits 3,4,6 report faults
// - Status bit 8 high at reference speed
// - Status bit 9 shows bus control
// - Status bit 11 shows running
// - Status bits 13,14,15 report limits
// - Link loss zeroes whole status word
// - Reference signed, 0x4000 is 100 percent
// - Actual value scaled like reference
module drive_control_status_word #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    input  wire logic              trip_in,
    input  wire logic              error_in,
    input  wire logic              triplock_in,
    input  wire logic              warning_in,
    input  wire logic              ctrl_ready_in,
    input  wire logic              drv_ready_in,
    input  wire logic              local_stop_in,
    input  wire logic              ref_site_local_in,
    input  wire logic              freq_in_limits_in,
    input  wire logic              overtemp_in,
    input  wire logic              dc_volt_bad_in,
    input  wire logic              current_limit_in,
    input  wire logic              thermal_over_in,
    input  wire logic              link_lost_in,
    input  wire logic              din_stop_in,
    input  wire logic              din_reverse_in,
    input  wire logic signed [15:0] motor_speed_in,
    input  wire logic signed [15:0] speed_max_in,
    output logic [1:0]             preset_sel_out,
    output logic                   dc_brake_out,
    output logic                   coast_out,
    output logic                   quick_stop_out,
    output logic                   freeze_out,
    output logic                   ramp_stop_out,
    output logic                   trip_reset_out,
    output logic                   jog_out,
    output logic                   ramp2_out,
    output logic                   relay1_out,
    output logic                   relay4_out,
    output logic [1:0]             setup_sel_out,
    output logic                   reverse_out,
    output logic [15:0]            drive_state_report_word_out,
    output logic signed [15:0]     actual_output_scaled_value_out
);
    import cw_pkg::*;

    logic [15:0]        ctrl_word_r;
    logic               reset_bit_prev_r;
    logic signed [15:0] speed_ref_r;
    logic [7:0]         relay1_fn_r;
    logic [7:0]         relay4_fn_r;
    logic [7:0]         setup_mode_r;
    rev_src_t           rev_src_r;
    logic [1:0]         setup_r;
    logic               aw_got_r;
    logic               w_got_r;
    logic [ADDR_W-1:0]  awaddr_r;
    logic [31:0]        wdata_r;
    logic [3:0]         wstrb_r;
    logic [15:0]        status_nxt;
    logic signed [31:0] scaled_nxt;
    logic               wr_go;
    logic               word_ok;

    assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid_out;

    // Write address and data accepted in either order
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= '0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr_in;
            end
            else if (wr_go)
            begin
                aw_got_r <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
            end
            else if (wr_go)
            begin
                w_got_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
        end
        else
        begin
            s_axi_awready_out <= !aw_got_r && !s_axi_awready_out
                                 && !(s_axi_awvalid_in && s_axi_awready_out);
            s_axi_wready_out  <= !w_got_r && !s_axi_wready_out
                                 && !(s_axi_wvalid_in && s_axi_wready_out);
        end
    end

    // Write response
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid_out <= 1'b1;
            unique case (awaddr_r[7:0])
                REG_CTRL_WORD, REG_SPEED_REF, REG_CONFIG:
                    s_axi_bresp_out <= RESP_OKAY;
                REG_STATE_WORD, REG_ACTUAL, REG_COMMANDS:
                    s_axi_bresp_out <= RESP_OKAY;
                default:
                    s_axi_bresp_out <= RESP_SLVERR;
            endcase
        end
        else if (s_axi_bvalid_out && s_axi_bready_in)
        begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    assign word_ok = wr_go && awaddr_r[7:0] == REG_CTRL_WORD
                     && wstrb_r[1:0] == 2'h3 && wdata_r[CW_VALID];

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_word_r <= CW_RESET_VAL;
        end
        else if (word_ok)
        begin
            ctrl_word_r <= wdata_r[15:0];
        end
    end

    // Configuration and reference writes
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            speed_ref_r  <= 16'sh0000;
            relay1_fn_r  <= 8'h00;
            relay4_fn_r  <= 8'h00;
            setup_mode_r <= 8'h00;
            rev_src_r    <= REV_DIGITAL;
        end
        else if (wr_go && awaddr_r[7:0] == REG_SPEED_REF)
        begin
            if (wstrb_r[0])
                speed_ref_r[7:0] <= wdata_r[7:0];
            if (wstrb_r[1])
                speed_ref_r[15:8] <= wdata_r[15:8];
        end
        else if (wr_go && awaddr_r[7:0] == REG_CONFIG)
        begin
            if (wstrb_r[0])
                relay1_fn_r <= wdata_r[7:0];
            if (wstrb_r[1])
                relay4_fn_r <= wdata_r[15:8];
            if (wstrb_r[2])
                setup_mode_r <= wdata_r[23:16];
            if (wstrb_r[3])
                rev_src_r <= rev_src_t'(wdata_r[25:24]);
        end
    end

    // Decoded commands
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            preset_sel_out <= 2'h0;
            dc_brake_out   <= 1'b0;
            coast_out      <= 1'b0;
            quick_stop_out <= 1'b0;
            freeze_out     <= 1'b0;
            ramp_stop_out  <= 1'b0;
            jog_out        <= 1'b0;
            ramp2_out      <= 1'b0;
        end
        else
        begin
            preset_sel_out <= ctrl_word_r[CW_PRESET_HI:CW_PRESET_LO];
            dc_brake_out   <= !ctrl_word_r[CW_DC_BRAKE_N];
            coast_out      <= !ctrl_word_r[CW_COAST_N];
            freeze_out     <= !ctrl_word_r[CW_FREEZE_N];
            quick_stop_out <= !ctrl_word_r[CW_QSTOP_N]
                              && ctrl_word_r[CW_FREEZE_N];
            ramp_stop_out  <= !ctrl_word_r[CW_RUN]
                              && ctrl_word_r[CW_FREEZE_N];
            jog_out        <= ctrl_word_r[CW_JOG];
            ramp2_out      <= ctrl_word_r[CW_RAMP2];
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            reset_bit_prev_r <= 1'b0;
            trip_reset_out   <= 1'b0;
        end
        else
        begin
            reset_bit_prev_r <= ctrl_word_r[CW_RESET];
            trip_reset_out   <= ctrl_word_r[CW_RESET] && !reset_bit_prev_r;
        end
    end

    // Relays, set-up and reversing
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            relay1_out    <= 1'b0;
            relay4_out    <= 1'b0;
            setup_r       <= SETUP_RESET;
            setup_sel_out <= SETUP_RESET;
            reverse_out   <= 1'b0;
        end
        else
        begin
            relay1_out <= relay1_fn_r == RELAY_FN_CW11
                          && ctrl_word_r[CW_RELAY1];
            relay4_out <= relay4_fn_r == RELAY_FN_CW12
                          && ctrl_word_r[CW_RELAY4];
            if (setup_mode_r == SETUP_MULTI)
                setup_r <= ctrl_word_r[CW_SETUP_HI:CW_SETUP_LO];
            setup_sel_out <= setup_r;
            unique case (rev_src_r)
                REV_DIGITAL:   reverse_out <= din_reverse_in;
                REV_SERIAL:    reverse_out <= ctrl_word_r[CW_REVERSE];
                REV_LOGIC_OR:  reverse_out <= ctrl_word_r[CW_REVERSE]
                                              || din_reverse_in;
                REV_LOGIC_AND: reverse_out <= ctrl_word_r[CW_REVERSE]
                                              && din_reverse_in;
            endcase
        end
    end

    // Status word assembly
    always_comb
    begin
        status_nxt                = SW_RESET_VAL;
        status_nxt[SW_CTRL_READY] = ctrl_ready_in && !trip_in;
        status_nxt[SW_DRV_READY]  = drv_ready_in;
        status_nxt[SW_ENABLE]     = ctrl_word_r[CW_COAST_N] && !din_stop_in;
        status_nxt[SW_TRIP]       = trip_in;
        status_nxt[SW_ERROR]      = error_in;
        status_nxt[SW_TRIPLOCK]   = triplock_in;
        status_nxt[SW_UNUSED]     = 1'b0;
        status_nxt[SW_WARNING]    = warning_in;
        status_nxt[SW_AT_REF]     = motor_speed_in == speed_ref_r;
        status_nxt[SW_BUS_CTRL]   = !local_stop_in && !ref_site_local_in;
        status_nxt[SW_FREQ_OK]    = freq_in_limits_in;
        status_nxt[SW_RUNNING]    = ctrl_word_r[CW_RUN]
                                    || motor_speed_in != 16'sh0000;
        status_nxt[SW_AUTO_STOP]  = overtemp_in;
        status_nxt[SW_VOLT_EXC]   = dc_volt_bad_in;
        status_nxt[SW_TORQ_EXC]   = current_limit_in;
        status_nxt[SW_TIMER_EXC]  = thermal_over_in;
        if (link_lost_in)
            status_nxt = SW_RESET_VAL;
    end

    always_comb
    begin
        scaled_nxt = 32'sh0000_0000;
        if (speed_max_in != 16'sh0000)
            scaled_nxt = (32'(motor_speed_in) <<< REF_SHIFT)
                         / 32'(speed_max_in);
        if (scaled_nxt > 32'sh0000_7FFF)
            scaled_nxt = 32'sh0000_7FFF;
        else if (scaled_nxt < -32'sh0000_8000)
            scaled_nxt = -32'sh0000_8000;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            drive_state_report_word_out    <= SW_RESET_VAL;
            actual_output_scaled_value_out <= 16'sh0000;
        end
        else
        begin
            drive_state_report_word_out    <= status_nxt;
            actual_output_scaled_value_out <= scaled_nxt[15:0];
        end
    end

    // Read channel
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= RESP_OKAY;
            unique case (s_axi_araddr_in[7:0])
                REG_CTRL_WORD:
                    s_axi_rdata_out <= {16'h0000, ctrl_word_r};
                REG_SPEED_REF:
                    s_axi_rdata_out <= {16'h0000, speed_ref_r};
                REG_CONFIG:
                    s_axi_rdata_out <= {6'h00, rev_src_r, setup_mode_r,
                                        relay4_fn_r, relay1_fn_r};
                REG_STATE_WORD:
                    s_axi_rdata_out <= {16'h0000,
                                        drive_state_report_word_out};
                REG_ACTUAL:
                    s_axi_rdata_out <= {16'h0000,
                                        actual_output_scaled_value_out};
                REG_COMMANDS:
                    s_axi_rdata_out <= {16'h0000, reverse_out, setup_sel_out,
                                        relay4_out, relay1_out, ramp2_out,
                                        jog_out, trip_reset_out,
                                        ramp_stop_out, freeze_out,
                                        quick_stop_out, coast_out,
                                        dc_brake_out, 1'b0, preset_sel_out};
                default:
                begin
                    s_axi_rdata_out <= 32'h0000_0000;
                    s_axi_rresp_out <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid_out)
        begin
            if (s_axi_rready_in)
            begin
                s_axi_rvalid_out  <= 1'b0;
            end
        end
        else
        begin
            s_axi_arready_out <= 1'b1;
        end
    end

endmodule : drive_control_status_word

`default_nettype wire

/* testbench/fieldbus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fieldbus_master_model (
    input  wire logic        clk_in,
    output logic [7:0]       awaddr_out,
    output logic             awvalid_out,
    input  wire logic        awready_in,
    output logic [31:0]      wdata_out,
    output logic             wvalid_out,
    input  wire logic        wready_in,
    input  wire logic        bvalid_in,
    output logic             bready_out,
    output logic [7:0]       araddr_out,
    output logic             arvalid_out,
    input  wire logic        arready_in,
    input  wire logic        rvalid_in,
    output logic             rready_out
);
    initial
    begin
        {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
        {awaddr_out, wdata_out, araddr_out} = '0;
    end

    // Address and data each held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        @(posedge clk_in);
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr_out  <= a;
        wdata_out   <= d;
        awvalid_out <= 1'b1;
        wvalid_out  <= 1'b1;
        bready_out  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk_in);
            if (!aw_done && awready_in)
            begin
                aw_done = 1'b1;
                awvalid_out <= 1'b0;
                awaddr_out  <= ~a;
            end
            if (!w_done && wready_in)
            begin
                w_done = 1'b1;
                wvalid_out <= 1'b0;
                wdata_out  <= ~d;
            end
        end
        do
            @(posedge clk_in);
        while (!bvalid_in);
        bready_out <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        araddr_out  <= a;
        arvalid_out <= 1'b1;
        rready_out  <= 1'b1;
        do
            @(posedge clk_in);
        while (!arready_in);
        arvalid_out <= 1'b0;
        araddr_out  <= ~a;
        do
            @(posedge clk_in);
        while (!rvalid_in);
        rready_out <= 1'b0;
    endtask : rd
endmodule : fieldbus_master_model

`default_nettype wire

/* testbench/drive_control_status_word_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module drive_control_status_word_asserts (
    input  wire logic               clk_in,
    input  wire logic               nrst_in,
    input  wire logic               trip_in,
    input  wire logic               error_in,
    input  wire logic               triplock_in,
    input  wire logic               local_stop_in,
    input  wire logic               ref_site_local_in,
    input  wire logic               dc_volt_bad_in,
    input  wire logic               current_limit_in,
    input  wire logic               thermal_over_in,
    input  wire logic               link_lost_in,
    input  wire logic signed [15:0] motor_speed_in,
    input  wire logic               coast_out,
    input  wire logic               freeze_out,
    input  wire logic               quick_stop_out,
    input  wire logic               ramp_stop_out,
    input  wire logic               trip_reset_out,
    input  wire logic [15:0]        drive_state_report_word_out
);
    import cw_pkg::*;
    wire logic [15:0] sw = drive_state_report_word_out;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_link_clear: assert property (link_lost_in |=> sw == 16'h0000)
        else $error("status word not cleared on link loss");
    a_spare_zero: assert property (sw[SW_UNUSED] == 1'b0)
        else $error("unused status bit set");
    a_fault_bits: assert property (!link_lost_in |=>
        sw[SW_TRIP] == $past(trip_in) && sw[SW_ERROR] == $past(error_in)
        && sw[SW_TRIPLOCK] == $past(triplock_in))
        else $error("fault bits wrong");
    a_limit_bits: assert property (!link_lost_in |=>
        sw[SW_VOLT_EXC] == $past(dc_volt_bad_in)
        && sw[SW_TORQ_EXC] == $past(current_limit_in)
        && sw[SW_TIMER_EXC] == $past(thermal_over_in))
        else $error("limit bits wrong");
    a_bus_ctrl: assert property (!link_lost_in |=>
        sw[SW_BUS_CTRL] == !($past(local_stop_in) || $past(ref_site_local_in)))
        else $error("bus control bit wrong");
    a_freeze_hold: assert property (freeze_out |->
        !quick_stop_out && !ramp_stop_out)
        else $error("ramp stop active while frozen");
    a_reset_pulse: assert property (trip_reset_out |=> !trip_reset_out)
        else $error("trip reset longer than one cycle");
    a_run_flag: assert property (!link_lost_in
        && motor_speed_in != 16'sh0000 |=> sw[SW_RUNNING])
        else $error("running bit low while turning");
    a_coast_enable: assert property (coast_out |-> !sw[SW_ENABLE])
        else $error("enable bit set while coasting");

    c_pulse: cover property (trip_reset_out);
    c_link: cover property (link_lost_in ##1 link_lost_in);
    c_freeze: cover property (freeze_out && coast_out);
endmodule : drive_control_status_word_asserts

bind drive_control_status_word drive_control_status_word_asserts chk (.*);

`default_nettype wire

/* testbench/drive_control_status_word_test.sv */
`timescale 1ns/1ps
`default_nettype none

module drive_control_status_word_test;
    import cw_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in = 4'hF;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, preset_sel_out;
    logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
    logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
    logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, reverse_out;
    logic trip_in, error_in, triplock_in, warning_in, ctrl_ready_in;
    logic local_stop_in, ref_site_local_in, freq_in_limits_in, overtemp_in;
    logic dc_volt_bad_in, current_limit_in, thermal_over_in, link_lost_in;
    logic din_stop_in, din_reverse_in, drv_ready_in, s_axi_rready_in;
    logic signed [15:0] motor_speed_in = 16'sh0000;
    logic signed [15:0] speed_max_in = 16'sh0000;
    logic signed [15:0] actual_output_scaled_value_out, sref;
    logic dc_brake_out, coast_out, quick_stop_out, freeze_out, ramp_stop_out;
    logic trip_reset_out, jog_out, ramp2_out, relay1_out, relay4_out;
    logic [15:0] drive_state_report_word_out, cw, fl = 16'h0000;
    logic [1:0]  setup_sel_out, su = 2'h0;
    logic [17:0] q[$];
    int fail_count = 0;
    int num_checks = 0;
    int pulses = 0;

    assign {din_reverse_in, din_stop_in, link_lost_in, thermal_over_in,
            current_limit_in, dc_volt_bad_in, overtemp_in, freq_in_limits_in,
            ref_site_local_in, local_stop_in, drv_ready_in, ctrl_ready_in,
            warning_in, triplock_in, error_in, trip_in} = fl;

    drive_control_status_word DUT (.*);

    fieldbus_master_model master (
        .clk_in      (clk_in),
        .awaddr_out  (s_axi_awaddr_in),
        .awvalid_out (s_axi_awvalid_in),
        .awready_in  (s_axi_awready_out),
        .wdata_out   (s_axi_wdata_in),
        .wvalid_out  (s_axi_wvalid_in),
        .wready_in   (s_axi_wready_out),
        .bvalid_in   (s_axi_bvalid_out),
        .bready_out  (s_axi_bready_in),
        .araddr_out  (s_axi_araddr_in),
        .arvalid_out (s_axi_arvalid_in),
        .arready_in  (s_axi_arready_out),
        .rvalid_in   (s_axi_rvalid_out),
        .rready_out  (s_axi_rready_in)
    );

    always #5 clk_in = ~clk_in;

    task automatic test_done;
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk(input logic [17:0] seen, input logic [17:0] want);
        num_checks++;
        if (seen !== want)
        begin
            fail_count++;
            $display("BAD %0t seen %0h want %0h", $time, seen, want);
        end
    endtask : chk

    task automatic w(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
        q.push_back({r, 16'h0000});
        master.wr(a, d);
    endtask : w

    task automatic rc(input logic [7:0] a, input logic [17:0] e);
        q.push_back(e);
        master.rd(a);
    endtask : rc

    function automatic logic [15:0] stat(input logic [15:0] c);
        stat = {fl[12:9], c[6] | (motor_speed_in != 16'sh0000),
                fl[8], ~fl[6] & ~fl[7], motor_speed_in == sref, fl[3:2],
                1'b0, fl[1:0], c[3] & ~fl[14], fl[5], fl[4] & ~fl[0]};
        if (fl[13])
            stat = 16'h0000;
    endfunction : stat

    function automatic logic [15:0] dec(input logic [15:0] c,
                                        input logic [1:0] s, input logic on);
        logic r;
        case (s)
            2'h0: r = fl[15];
            2'h1: r = c[15];
            2'h2: r = c[15] | fl[15];
            default: r = c[15] & fl[15];
        endcase
        dec = {r, on ? c[14:13] : su, c[12] & on, c[11] & on, c[9], c[8], 1'b0,
               ~c[6] & c[5], ~c[5], ~c[4] & c[5], ~c[3], ~c[2], 1'b0, c[1:0]};
    endfunction : dec

    always @(posedge clk_in)
    begin
        if (s_axi_bvalid_out === 1'b1 && s_axi_bready_in === 1'b1)
            chk({s_axi_bresp_out, 16'h0000}, q.pop_front());
        if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in === 1'b1)
            chk({s_axi_rresp_out, s_axi_rdata_out[15:0]}, q.pop_front());
    end

    always @(posedge clk_in)
        if (trip_reset_out === 1'b1)
            pulses++;

    initial
    begin
        #100000;
        fail_count++;
        test_done();
    end

    initial
    begin
        logic [15:0] c;
        void'($urandom(46840));
        repeat (16) @(posedge clk_in);
        nrst_in      <= 1'b1;
        speed_max_in <= 16'sh1000;
        w(8'h18, 32'h0000_0001, RESP_SLVERR);
        rc(8'h18, {RESP_SLVERR, 16'h0000});
        for (int k = 0; k < 4; k++)
        begin
            sref = 16'($urandom_range(0, 16'h1FFF)) - 16'sh1000;
            w(REG_SPEED_REF, {{16{sref[15]}}, sref}, RESP_OKAY);
            w(REG_CONFIG, {6'h00, 2'(k), SETUP_MULTI, RELAY_FN_CW12,
                           RELAY_FN_CW11}, RESP_OKAY);
            for (int i = 0; i < 6; i++)
            begin
                c = (16'($urandom) | 16'h0400) & 16'hFF7F;
                if (i == 5)
                    c[10] = 1'b0;
                else
                    cw = c;
                su = cw[14:13];
                fl <= 16'($urandom) & 16'hDFFF;
                motor_speed_in <= (i % 2 == 1) ? sref
                    : 16'($urandom_range(0, 16'h2000)) - 16'sh1000;
                w(REG_CTRL_WORD, {16'h0000, c}, RESP_OKAY);
                rc(REG_COMMANDS, {RESP_OKAY, dec(cw, 2'(k), 1'b1)});
                rc(REG_STATE_WORD, {RESP_OKAY, stat(cw)});
                rc(REG_ACTUAL, {RESP_OKAY, 16'(motor_speed_in * 4)});
            end
        end
        w(REG_CONFIG, 32'h0100_0000, RESP_OKAY);
        cw = cw ^ 16'h7800;
        w(REG_CTRL_WORD, {16'h0000, cw}, RESP_OKAY);
        rc(REG_COMMANDS, {RESP_OKAY, dec(cw, 2'h1, 1'b0)});
        w(REG_CTRL_WORD, {16'h0000, cw | 16'h0080}, RESP_OKAY);
        w(REG_CTRL_WORD, {16'h0000, cw | 16'h0080}, RESP_OKAY);
        w(REG_CTRL_WORD, {16'h0000, cw}, RESP_OKAY);
        chk({2'b00, 16'(pulses)}, 18'h00001);
        w(REG_STATE_WORD, 32'h0000_FFFF, RESP_OKAY);
        rc(REG_STATE_WORD, {RESP_OKAY, stat(cw)});
        fl <= 16'hFFFF;
        rc(REG_STATE_WORD, {RESP_OKAY, 16'h0000});
        test_done();
    end
endmodule : drive_control_status_word_test

`default_nettype wire
